// File: logic/flash_host_defs.vh
// shared constants of the serial flash host controller
`ifndef FLASH_HOST_DEFS_VH
`define FLASH_HOST_DEFS_VH

// register word addresses on the avalon slave
`define REG_CMD 3'h0
`define REG_ADDR 3'h1
`define REG_WDATA 3'h2
`define REG_RDATA 3'h3
`define REG_STATUS 3'h4
`define REG_CFG 3'h5

// command register fields
`define CMD_OP_LSB 0
`define CMD_LEN_LSB 8
`define MAX_LEN 3'h4

// status register fields
`define STAT_ACTIVE 0
`define STAT_DONE 1
`define STAT_REFUSED 2
`define STAT_DEV_LSB 8

// config register fields and reset value
`define CFG_QUAD 0
`define CFG_POLL 1
`define CFG_MODE_LSB 4
`define CFG_RST_QUAD 1'b0
`define CFG_RST_POLL 1'b1
`define CFG_RST_MODE 4'h0

// device status byte bits
`define DEV_BUSY 0
`define DEV_LATCH 1

// flash opcodes
`define OP_FREAD 8'h0b
`define OP_FREAD_DO 8'h3b
`define OP_FREAD_QO 8'h6b
`define OP_FREAD_DIO 8'hbb
`define OP_FREAD_QIO 8'heb
`define OP_PROG 8'h02
`define OP_QPROG 8'h32
`define OP_SECT_ERASE 8'h20
`define OP_HALF_ERASE 8'h52
`define OP_WREN 8'h06
`define OP_RDSTAT 8'h05

// dummy clocks and page size
`define DUMMY_FAST 4'h8
`define DUMMY_QIO 4'h4
`define PAGE_BYTES 10'h100

// frame kinds of one command
`define FR_WREN 2'h0
`define FR_MAIN 2'h1
`define FR_POLL 2'h2

// chip select high time between frames
`define SYS_CLK_NS 10
`define CS_HIGH_NS 50
`define CS_HIGH_CYC ((`CS_HIGH_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

`endif

// File: logic/spi_lane_shifter.v
// serial clock generator and 1/2/4 lane byte shifter
`timescale 1ns/1ns
`include "flash_host_defs.vh"

module spi_lane_shifter #(
  parameter HALF = 4
) (
  input wire clk_sys,
  input wire rstn,
  input wire go,
  input wire [3:0] clocks,
  input wire [2:0] lanes,
  input wire drive,
  input wire [7:0] tx,
  output wire done,
  output wire [7:0] rx,
  output wire sclk,
  output wire [3:0] lane_o,
  output wire [3:0] lane_oe,
  input wire [3:0] lane_i
);

  localparam [7:0] HALF_M1 = HALF - 1;

  reg [3:0] sync1_r; // first stage, read only by sync2_r
  reg [3:0] sync2_r; // lanes as seen by the logic
  reg [7:0] sh_r; // shift register
  reg [3:0] left_r; // clocks still to run
  reg [7:0] cnt_r; // half period counter
  reg act_r; // unit running
  reg hi_r; // serial clock high phase
  reg done_r;
  reg [7:0] rx_r;
  reg sclk_r;
  reg [3:0] lane_o_r;
  reg [3:0] lane_oe_r;
  reg [2:0] lanes_r;

  // lanes 2 and 3 idle high outside quad so hold and protect stay inactive
  function [3:0] out_of;
    input [7:0] sh;
    input [2:0] ln;
    begin
      if (ln == 3'h4) begin
        out_of = sh[7:4]; // lane3 carries the top bit of the nibble
      end else if (ln == 3'h2) begin
        out_of = {2'b11, sh[7:6]};
      end else begin
        out_of = {2'b11, 1'b0, sh[7]};
      end
    end
  endfunction

  // lanes the host drives for a given width and direction
  function [3:0] oe_of;
    input [2:0] ln;
    input dr;
    begin
      if (ln == 3'h4) begin
        oe_of = dr ? 4'hf : 4'h0;
      end else if (ln == 3'h2) begin
        oe_of = dr ? 4'hf : 4'hc;
      end else begin
        oe_of = 4'hd; // lane1 is the device output in single mode
      end
    end
  endfunction

  // byte after one more clock, incoming bits enter at the bottom
  wire [7:0] sh_in = (lanes_r == 3'h4) ? {sh_r[3:0], sync2_r} :
                     (lanes_r == 3'h2) ? {sh_r[5:0], sync2_r[1:0]} : {sh_r[6:0], sync2_r[1]};

  // two flop synchroniser for the lanes
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= lane_i;
      sync2_r <= sync1_r;
    end
  end

  // mode 0: outputs change while clock low, input taken at end of high phase
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sh_r <= 8'h00;
      left_r <= 4'h0;
      cnt_r <= 8'h00;
      act_r <= 1'b0;
      hi_r <= 1'b0;
      done_r <= 1'b0;
      rx_r <= 8'h00;
      sclk_r <= 1'b0;
      lane_o_r <= 4'hc;
      lane_oe_r <= 4'hd;
      lanes_r <= 3'h1;
    end else begin
      done_r <= 1'b0;
      if (!act_r) begin
        // idle: clock rests low
        if (go) begin
          sh_r <= tx;
          left_r <= clocks;
          lanes_r <= lanes;
          lane_o_r <= out_of(tx, lanes);
          lane_oe_r <= oe_of(lanes, drive); // released a full half period before the edge
          cnt_r <= HALF_M1;
          hi_r <= 1'b0;
          act_r <= 1'b1;
        end
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end else if (!hi_r) begin
        // rising edge: device latches our bits
        sclk_r <= 1'b1;
        hi_r <= 1'b1;
        cnt_r <= HALF_M1;
      end else begin
        // falling edge: take device bits, present next ones
        sh_r <= sh_in;
        sclk_r <= 1'b0;
        hi_r <= 1'b0;
        cnt_r <= HALF_M1;
        if (left_r == 4'h1) begin
          act_r <= 1'b0;
          done_r <= 1'b1;
          rx_r <= sh_in;
        end else begin
          left_r <= left_r - 4'h1;
          lane_o_r <= out_of(sh_in, lanes_r);
        end
      end
    end
  end

  assign done = done_r;
  assign rx = rx_r;
  assign sclk = sclk_r;
  assign lane_o = lane_o_r;
  assign lane_oe = lane_oe_r;

endmodule

// File: logic/flash_host_ctrl.v
// serial flash host: avalon registers in, read/program/erase frames out
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "flash_host_defs.vh"


module flash_host_ctrl #(
  parameter SCLK_HALF = 4
) (
  input wire clk_sys,
  input wire rstn,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire spi_cs_n,
  output wire spi_sclk,
  output wire [3:0] lane_o,
  output wire [3:0] lane_oe,
  input wire [3:0] lane_i
);

  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_SETUP = 9'h002;
  localparam [8:0] S_OPC = 9'h004;
  localparam [8:0] S_ADR = 9'h008;
  localparam [8:0] S_MODE = 9'h010;
  localparam [8:0] S_DUM = 9'h020;
  localparam [8:0] S_DAT = 9'h040;
  localparam [8:0] S_END = 9'h080;
  localparam [8:0] S_GAP = 9'h100;
  localparam [7:0] HALF_M1 = SCLK_HALF - 1;
  localparam [7:0] GAP_M1 = `CS_HIGH_CYC - 1;

  reg [8:0] state_r;
  reg [8:0] state_nxt;
  reg [7:0] op_r; // opcode of the main frame
  reg [2:0] len_r; // data bytes of the main frame
  reg [23:0] addr_r;
  reg [31:0] wdata_r; // first byte sent from bits 7:0
  reg [31:0] rdata_r; // first byte read lands in bits 7:0
  reg [7:0] dev_stat_r; // last status byte polled
  reg cfg_quad_r; // software mirror of the device quad enable bit
  reg cfg_poll_r; // poll busy after program and erase
  reg [3:0] mode_nib_r; // low nibble of the continuous mode byte
  reg [1:0] frame_r;
  reg [2:0] idx_r; // byte index inside address or data phase
  reg [7:0] cnt_r; // select setup, hold and high time
  reg active_r;
  reg done_r;
  reg refused_r;
  reg cs_n_r;
  reg [31:0] readdata_r;
  reg waitreq_r;
  reg go_r; // one cycle launch for the shifter
  reg [3:0] clocks_r;
  reg [2:0] lanes_r;
  reg drive_r;
  reg [7:0] tx_r;

  wire phy_done;
  wire [7:0] phy_rx;

  // address, mode, dummy, data format of an opcode: {rd, data lanes, dummies, mode, addr lanes}
  function [11:0] cmd_fmt;
    input [7:0] op;
    begin
      case (op)
        `OP_FREAD: cmd_fmt = {1'b1, 3'h1, `DUMMY_FAST, 1'b0, 3'h1};
        `OP_FREAD_DO: cmd_fmt = {1'b1, 3'h2, `DUMMY_FAST, 1'b0, 3'h1};
        `OP_FREAD_QO: cmd_fmt = {1'b1, 3'h4, `DUMMY_FAST, 1'b0, 3'h1};
        `OP_FREAD_DIO: cmd_fmt = {1'b1, 3'h2, 4'h0, 1'b1, 3'h2}; // mode byte fills the four dummies
        `OP_FREAD_QIO: cmd_fmt = {1'b1, 3'h4, `DUMMY_QIO, 1'b1, 3'h4};
        `OP_PROG: cmd_fmt = {1'b0, 3'h1, 4'h0, 1'b0, 3'h1};
        `OP_QPROG: cmd_fmt = {1'b0, 3'h4, 4'h0, 1'b0, 3'h4};
        `OP_SECT_ERASE: cmd_fmt = {1'b0, 3'h0, 4'h0, 1'b0, 3'h1};
        `OP_HALF_ERASE: cmd_fmt = {1'b0, 3'h0, 4'h0, 1'b0, 3'h1};
        `OP_WREN: cmd_fmt = 12'h000;
        default: cmd_fmt = {1'b1, 3'h1, 4'h0, 1'b0, 3'h0}; // status reads and others: opcode then data
      endcase
    end
  endfunction

  // opcodes that need the device quad enable bit
  function is_quad;
    input [7:0] op;
    begin
      is_quad = (op == `OP_FREAD_QO) || (op == `OP_FREAD_QIO) || (op == `OP_QPROG);
    end
  endfunction

  // page program opcodes
  function is_prog;
    input [7:0] op;
    begin
      is_prog = (op == `OP_PROG) || (op == `OP_QPROG);
    end
  endfunction

  // opcodes that start a self-timed cycle
  function is_cycle;
    input [7:0] op;
    begin
      is_cycle = is_prog(op) || (op == `OP_SECT_ERASE) || (op == `OP_HALF_ERASE);
    end
  endfunction

  // serial clocks per byte for a lane count
  function [3:0] clk_of;
    input [2:0] ln;
    begin
      if (ln == 3'h4) begin
        clk_of = 4'h2;
      end else if (ln == 3'h2) begin
        clk_of = 4'h4;
      end else begin
        clk_of = 4'h8;
      end
    end
  endfunction

  // current frame opcode and its format
  wire [7:0] cur_op = (frame_r == `FR_WREN) ? `OP_WREN : (frame_r == `FR_POLL) ? `OP_RDSTAT : op_r;
  wire [11:0] fmt = cmd_fmt(cur_op);
  wire [2:0] adr_ln = fmt[2:0];
  wire has_mode = fmt[3];
  wire [3:0] dummies = fmt[7:4];
  wire [2:0] dat_ln = fmt[10:8];
  wire dat_rd = fmt[11];
  wire [2:0] nbytes = (frame_r == `FR_WREN) ? 3'h0 : (frame_r == `FR_POLL) ? 3'h1 :
                      (dat_ln == 3'h0) ? 3'h0 : len_r;

  // phase order inside a frame
  wire [8:0] after_dum = (nbytes != 3'h0) ? S_DAT : S_END;
  wire [8:0] after_mode = (dummies != 4'h0) ? S_DUM : after_dum;
  wire [8:0] after_adr = has_mode ? S_MODE : after_mode;
  wire [8:0] after_opc = (adr_ln != 3'h0) ? S_ADR : after_adr;

  // frame that follows the current one
  wire poll_more = (frame_r == `FR_POLL) && dev_stat_r[`DEV_BUSY]; // keep polling while busy
  wire main_next = (frame_r == `FR_MAIN) && is_cycle(op_r) && cfg_poll_r;
  wire more_frame = (frame_r == `FR_WREN) || main_next || poll_more;
  wire [1:0] frame_nxt = (frame_r == `FR_WREN) ? `FR_MAIN : `FR_POLL;

  // avalon handshake and command acceptance
  wire ack = (avs_read || avs_write) && !waitreq_r;
  wire cmd_wr = ack && avs_write && (avs_address == `REG_CMD);
  wire [7:0] new_op = avs_writedata[`CMD_OP_LSB +: 8];
  wire [2:0] raw_len = avs_writedata[`CMD_LEN_LSB +: 3];
  wire [2:0] new_len = (raw_len > `MAX_LEN) ? `MAX_LEN : raw_len;
  wire [9:0] page_end = {2'b00, addr_r[7:0]} + {7'h00, new_len};
  wire bad_quad = is_quad(new_op) && !cfg_quad_r;
  wire bad_page = is_prog(new_op) && ((new_len == 3'h0) || (page_end > `PAGE_BYTES));
  wire start_ok = cmd_wr && !active_r && !bad_quad && !bad_page;

  // launch a shifter unit on entry to a phase or on each further byte
  wire unit_nxt = (state_nxt & (S_OPC | S_ADR | S_MODE | S_DUM | S_DAT)) != 9'h000;
  wire launch = unit_nxt && ((state_nxt != state_r) || phy_done);
  wire [2:0] idx_use = (state_nxt == state_r) ? (idx_r + 3'h1) : 3'h0;
  wire [4:0] abit = 5'h10 - {idx_use[1:0], 3'h0}; // address high byte first

  // phase sequencing
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (start_ok) begin
          state_nxt = S_SETUP;
        end
      end
      S_SETUP: begin
        if (cnt_r == 8'h00) begin
          state_nxt = S_OPC;
        end
      end
      S_OPC: begin
        if (phy_done) begin
          state_nxt = after_opc;
        end
      end
      S_ADR: begin
        if (phy_done && (idx_r == 3'h2)) begin
          state_nxt = after_adr;
        end
      end
      S_MODE: begin
        if (phy_done) begin
          state_nxt = after_mode;
        end
      end
      S_DUM: begin
        if (phy_done) begin
          state_nxt = after_dum;
        end
      end
      S_DAT: begin
        if (phy_done && ((idx_r + 3'h1) == nbytes)) begin
          state_nxt = S_END;
        end
      end
      S_END: begin
        if (cnt_r == 8'h00) begin
          state_nxt = S_GAP;
        end
      end
      S_GAP: begin
        if (cnt_r == 8'h00) begin
          state_nxt = more_frame ? S_SETUP : S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // frame engine
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= S_IDLE;
      op_r <= 8'h00;
      len_r <= 3'h0;
      frame_r <= `FR_MAIN;
      idx_r <= 3'h0;
      cnt_r <= 8'h00;
      active_r <= 1'b0;
      done_r <= 1'b0;
      refused_r <= 1'b0;
      cs_n_r <= 1'b1;
      rdata_r <= 32'h00000000;
      dev_stat_r <= 8'h00;
      go_r <= 1'b0;
      clocks_r <= 4'h8;
      lanes_r <= 3'h1;
      drive_r <= 1'b1;
      tx_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      go_r <= launch;
      // a refused command never reaches the pins
      if (cmd_wr) begin
        refused_r <= !start_ok;
      end
      if (start_ok) begin
        op_r <= new_op;
        len_r <= new_len;
        frame_r <= is_cycle(new_op) ? `FR_WREN : `FR_MAIN; // latch set first
        active_r <= 1'b1;
        done_r <= 1'b0;
        rdata_r <= 32'h00000000;
      end
      // select timing
      if (state_nxt == S_SETUP && state_r != S_SETUP) begin
        cs_n_r <= 1'b0;
        cnt_r <= HALF_M1;
      end else if (state_nxt == S_END && state_r != S_END) begin
        cnt_r <= HALF_M1;
      end else if (state_nxt == S_GAP && state_r != S_GAP) begin
        cs_n_r <= 1'b1; // only after whole bytes
        cnt_r <= GAP_M1;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
      if (state_r == S_GAP && cnt_r == 8'h00) begin
        if (more_frame) begin
          frame_r <= frame_nxt;
        end else begin
          active_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
      // capture read bytes, dummy bits are never stored
      if (phy_done && state_r == S_DAT && dat_rd) begin
        if (frame_r == `FR_POLL) begin
          dev_stat_r <= phy_rx; // busy and latch bits, readable any time
        end else begin
          rdata_r[{idx_r[1:0], 3'h0} +: 8] <= phy_rx;
        end
      end
      // unit parameters for the shifter
      if (launch) begin
        idx_r <= idx_use;
        if (state_nxt == S_OPC) begin
          clocks_r <= 4'h8;
          lanes_r <= 3'h1;
          drive_r <= 1'b1;
          tx_r <= cur_op;
        end else if (state_nxt == S_ADR) begin
          clocks_r <= clk_of(adr_ln);
          lanes_r <= adr_ln;
          drive_r <= 1'b1;
          tx_r <= addr_r[abit +: 8];
        end else if (state_nxt == S_MODE) begin
          clocks_r <= clk_of(adr_ln);
          lanes_r <= adr_ln;
          drive_r <= 1'b1;
          tx_r <= {4'hf, mode_nib_r};
        end else if (state_nxt == S_DUM) begin
          clocks_r <= dummies;
          lanes_r <= dat_ln;
          drive_r <= (dat_ln == 3'h1); // multi-lane reads free the lanes here
          tx_r <= 8'h00;
        end else begin
          clocks_r <= clk_of(dat_ln);
          lanes_r <= dat_ln;
          drive_r <= !dat_rd;
          tx_r <= wdata_r[{idx_use[1:0], 3'h0} +: 8]; // sent as given, software keeps it to erased bytes
        end
      end
    end
  end

  // avalon slave: one wait cycle, then a single cycle answer
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      waitreq_r <= 1'b1;
      readdata_r <= 32'h00000000;
      addr_r <= 24'h000000;
      wdata_r <= 32'h00000000;
      cfg_quad_r <= `CFG_RST_QUAD;
      cfg_poll_r <= `CFG_RST_POLL;
      mode_nib_r <= `CFG_RST_MODE;
    end else begin
      waitreq_r <= !((avs_read || avs_write) && waitreq_r);
      if (avs_read && waitreq_r) begin
        if (avs_address == `REG_CMD) begin
          readdata_r <= {21'h000000, len_r, op_r};
        end else if (avs_address == `REG_ADDR) begin
          readdata_r <= {8'h00, addr_r};
        end else if (avs_address == `REG_WDATA) begin
          readdata_r <= wdata_r;
        end else if (avs_address == `REG_RDATA) begin
          readdata_r <= rdata_r;
        end else if (avs_address == `REG_STATUS) begin
          readdata_r <= {16'h0000, dev_stat_r, 5'h00, refused_r, done_r, active_r};
        end else if (avs_address == `REG_CFG) begin
          readdata_r <= {24'h000000, mode_nib_r, 2'b00, cfg_poll_r, cfg_quad_r};
        end else begin
          readdata_r <= 32'h00000000; // unmapped reads as zero
        end
      end
      // address and data are frozen while a command runs
      if (ack && avs_write && !active_r) begin
        if (avs_address == `REG_ADDR) begin
          addr_r <= avs_writedata[23:0];
        end else if (avs_address == `REG_WDATA) begin
          wdata_r <= avs_writedata;
        end else if (avs_address == `REG_CFG) begin
          cfg_quad_r <= avs_writedata[`CFG_QUAD];
          cfg_poll_r <= avs_writedata[`CFG_POLL];
          mode_nib_r <= avs_writedata[`CFG_MODE_LSB +: 4];
        end
      end
    end
  end

  spi_lane_shifter #(
    .HALF(SCLK_HALF)
  ) u_shift (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .go(go_r),
    .clocks(clocks_r),
    .lanes(lanes_r),
    .drive(drive_r),
    .tx(tx_r),
    .done(phy_done),
    .rx(phy_rx),
    .sclk(spi_sclk),
    .lane_o(lane_o),
    .lane_oe(lane_oe),
    .lane_i(lane_i)
  );

  assign avs_readdata = readdata_r;
  assign avs_waitrequest = waitreq_r;
  assign spi_cs_n = cs_n_r;

endmodule

// File: tb/flash_host_ctrl_props.sv
// timing checks on the flash host ports
`timescale 1ns/1ns
module flash_host_ctrl_props #(
  parameter SCLK_HALF = 4
) (
  input wire clk_sys,
  input wire rstn,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire spi_cs_n,
  input wire spi_sclk,
  input wire [3:0] lane_o,
  input wire [3:0] lane_oe
);
  reg [7:0] hi_r; // cycles the clock has been high
  reg [2:0] nr_r; // rising clocks in frame, mod 8
  reg wide_r; // frame clocked more than one lane, clocks no longer count bits
  wire wide_nxt = !spi_cs_n && (wide_r || (spi_sclk && lane_oe != 4'hd));
  wire [7:0] hi_nxt = spi_sclk ? hi_r + 8'h01 : 8'h00;
  wire [2:0] nr_nxt = spi_cs_n ? 3'h0 : nr_r + {2'h0, spi_sclk && hi_r == 8'h00};
  // helper counters
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hi_r <= 8'h00;
      nr_r <= 3'h0;
      wide_r <= 1'b0;
    end else begin
      hi_r <= hi_nxt;
      nr_r <= nr_nxt;
      wide_r <= wide_nxt;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_lead; !spi_sclk [*4]; endsequence
  sequence s_gap; spi_cs_n [*5]; endsequence
  property p_wait_answer; s_req |=> !avs_waitrequest; endproperty
  property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_wait_idle; !(avs_read || avs_write) |=> avs_waitrequest; endproperty
  property p_sclk_idle; spi_cs_n |-> !spi_sclk; endproperty
  property p_cs_gap; $rose(spi_cs_n) |-> s_gap; endproperty
  property p_cs_lead; $fell(spi_cs_n) |-> s_lead; endproperty
  property p_sclk_high; $fell(spi_sclk) |-> hi_r == SCLK_HALF; endproperty
  property p_lanes_hold; spi_sclk && $past(spi_sclk) |-> $stable(lane_o) && $stable(lane_oe); endproperty
  property p_cs_byte; $rose(spi_cs_n) && !wide_r |-> nr_r == 3'h0; endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no answer after request");
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
  a_sclk_idle: assert property (p_sclk_idle) else $error("clock high while deselected");
  a_cs_gap: assert property (p_cs_gap) else $error("deselect too short");
  a_cs_lead: assert property (p_cs_lead) else $error("clock too soon after select");
  a_sclk_high: assert property (p_sclk_high) else $error("clock high phase wrong");
  a_lanes_hold: assert property (p_lanes_hold) else $error("lanes moved while clock high");
  a_cs_byte: assert property (p_cs_byte) else $error("deselect off byte boundary");
endmodule
bind flash_host_ctrl flash_host_ctrl_props #(.SCLK_HALF(SCLK_HALF)) u_props (.clk_sys(clk_sys), .rstn(rstn),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .spi_cs_n(spi_cs_n),
  .spi_sclk(spi_sclk), .lane_o(lane_o), .lane_oe(lane_oe));

// File: tb/flash_dev_model.sv
// behavioural serial flash, single-lane input, 1, 2 or 4 lane fast read output
`timescale 1ns/1ns
module flash_dev_model #(
  parameter T_BUSY = 3000, // short self-timed cycle
  parameter [23:0] PROT_BASE = 24'h800000 // upper half stands for a protected range
) (
  input wire cs_n,
  input wire sclk,
  input wire si,
  output reg [3:0] dq, // lane levels driven, lane1 alone in single mode
  output reg dq_oe
);
  reg [7:0] mem [0:255]; // one page stands for the array
  reg [7:0] op, sh, ix, st, b;
  reg [23:0] adr;
  reg busy, latch;
  reg [7:0] pq [$]; // staged program bytes
  int n, k, w, m;
  initial begin
    foreach (mem[j]) mem[j] = 8'hff;
    busy = 0;
    latch = 0;
    dq = 0;
    dq_oe = 0;
  end
  // new frame
  always @(negedge cs_n) begin
    n = 0;
    pq.delete();
  end
  // inputs sampled on rising clock
  always @(posedge sclk) if (!cs_n) begin
    sh = {sh[6:0], si};
    n++;
    if (n == 8) op = sh;
    if (n > 8 && n <= 32) adr = {adr[22:0], si};
    if (n > 32 && n % 8 == 0) pq.push_back(sh);
  end
  // output on falling clock, 1, 2 or 4 lanes; released during dummies
  always @(negedge sclk) if (!cs_n) begin
    k = 7 - n % 8;
    st = {6'h0, latch, busy};
    w = (op == 8'h6b) ? 4 : (op == 8'h3b) ? 2 : 1;
    m = (n - 40) * w; // data bits already sent
    dq_oe = 0;
    if (op == 8'h05 && n >= 8) begin
      dq_oe = 1;
      dq = {2'b00, st[k], 1'b0};
    end else if ((op == 8'h0b || op == 8'h3b || op == 8'h6b) && n >= 40 && !busy) begin
      ix = adr[7:0] + 8'(m / 8);
      b = mem[ix] << (m % 8);
      dq_oe = 1;
      dq = (w == 4) ? b[7:4] : (w == 2) ? {2'b00, b[7:6]} : {2'b00, b[7], 1'b0};
    end
  end
  // commands act on deselect, only on whole bytes and when idle
  always @(posedge cs_n) begin
    dq_oe = 0;
    if (n % 8 == 0 && !busy) begin
      if (op == 8'h06 && n == 8) latch = 1;
      // protected addresses are skipped whole, latch left as it was
      if (latch && adr < PROT_BASE &&
          ((op == 8'h02 && n > 32) || ((op == 8'h20 || op == 8'h52) && n == 32))) begin
        if (op != 8'h02) foreach (mem[j]) mem[j] = 8'hff;
        foreach (pq[i]) begin
          ix = adr[7:0] + 8'(i);
          mem[ix] = mem[ix] & pq[i];
        end
        busy = 1;
        busy <= #T_BUSY 1'b0;
        latch <= #T_BUSY 1'b0;
      end
    end
  end
endmodule

// File: tb/flash_host_ctrl_tb.sv
// self-checking bench: avalon tasks drive the host, a flash model answers
`timescale 1ns/1ns
module flash_host_ctrl_tb;
  logic clk_sys, rstn, avs_read, avs_write;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, rdat, seed, d;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, spi_cs_n, spi_sclk, dq_oe;
  wire [3:0] lane_o, lane_oe, lane_i, dq;
  logic [63:0] q [$]; // expected reads {mask, value}
  logic [63:0] p;
  logic [39:0] bad [5]; // refused {op, len, addr}
  int n_errors, total_checks, i, j;
  // lanes released by both host and model show the inverse of what was last on them
  assign lane_i = (lane_oe & lane_o) | (~lane_oe & (dq_oe ? dq : ~lane_o));
  flash_host_ctrl u_dut (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .lane_o(lane_o),
    .lane_oe(lane_oe), .lane_i(lane_i));
  flash_dev_model u_flash (.cs_n(spi_cs_n), .sclk(spi_sclk), .si(lane_i[0]), .dq(dq), .dq_oe(dq_oe));
  // 100 MHz clock
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task check(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task close_out;
    if (n_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [2:0] a, input logic [31:0] dt, input logic [31:0] m, input logic [31:0] e);
    avs_address <= a;
    avs_writedata <= dt;
    avs_write <= w;
    avs_read <= !w;
    if (!w) q.push_back({m, e});
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge clk_sys);
  endtask
  task go(input logic [7:0] op, input logic [2:0] ln, input logic [23:0] a, input logic [31:0] dt);
    bus(1, 3'h1, {8'h00, a}, 0, 0);
    bus(1, 3'h2, dt, 0, 0);
    bus(1, 3'h0, {21'h0, ln, op}, 0, 0);
  endtask
  // poll until the done flag is up
  task fin;
    do bus(0, 3'h4, 0, 0, 0); while (rdat[1] !== 1'b1);
  endtask
  // read results are compared against the oldest note
  always @(posedge clk_sys) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      p = q.pop_front();
      if (p[63:32] != 0) check(avs_readdata & p[63:32], p[31:0]);
    end
  end
  // watchdog
  initial begin
    #600000;
    n_errors++;
    close_out;
  end
  initial begin
    rstn = 0;
    avs_read = 0;
    avs_write = 0;
    avs_address = 3'h0;
    avs_writedata = 32'h0;
    seed = 32'h55;
    bad = '{{8'h6b, 8'h04, 24'h10}, {8'heb, 8'h04, 24'h10}, {8'h32, 8'h04, 24'h10},
            {8'h02, 8'h00, 24'h10}, {8'h02, 8'h04, 24'hfd}};
    repeat (3) @(posedge clk_sys);
    check({avs_waitrequest, spi_cs_n, spi_sclk, lane_oe, lane_o}, {1'b1, 1'b1, 1'b0, 4'hd, 4'hc});
    rstn <= 1;
    @(posedge clk_sys);
    bus(0, 3'h5, 0, '1, 32'h2);
    bus(0, 3'h7, 0, '1, 32'h0);
    for (i = 0; i < 5; i++) begin
      go(bad[i][39:32], bad[i][26:24], bad[i][23:0], xs());
      bus(0, 3'h4, 0, 32'h4, 32'h4);
    end
    go(8'h0b, 3'h4, 24'hfc, 0);
    fin;
    bus(0, 3'h3, 0, '1, '1);
    bus(1, 3'h5, 32'h3, 0, 0);
    bus(0, 3'h5, 0, '1, 32'h3);
    for (i = 0; i < 2; i++) begin
      d = xs();
      go(8'h02, 3'h4, 24'hfc, d);
      fin;
      bus(0, 3'h4, 0, 32'hff06, 32'h2);
      bus(0, 3'h0, 0, '1, 32'h402);
      for (j = 0; j < 3; j++) begin
        go(j == 0 ? 8'h0b : j == 1 ? 8'h3b : 8'h6b, 3'h4, 24'hfc, 0);
        fin;
        bus(0, 3'h3, 0, '1, d);
      end
      go(i ? 8'h52 : 8'h20, 3'h0, 24'h0, 0);
      fin;
      bus(0, 3'h4, 0, 32'hff06, 32'h2);
      go(8'h0b, 3'h4, 24'hfc, 0);
      fin;
      bus(0, 3'h3, 0, '1, '1);
    end
    // program into the protected range: skipped, latch stays, page keeps erased bytes
    go(8'h02, 3'h4, 24'h8000fc, 0);
    fin;
    bus(0, 3'h4, 0, 32'hff06, 32'h202);
    go(8'h0b, 3'h4, 24'hfc, 0);
    fin;
    bus(0, 3'h3, 0, '1, '1);
    close_out;
  end
endmodule
